// File: src/port_alt_io.sv
`timescale 1ns/100ps
`default_nettype none
module port_alt_io
(
  input wire logic clk_i,
  input wire logic rstn_i,
  // Core side latch writes, latch values and port reads
  input wire logic p1_wr_i,
  input wire logic [port_io_pkg::PORT_W-1:0] p1_wdata_i,
  input wire logic p3_wr_i,
  input wire logic [port_io_pkg::PORT_W-1:0] p3_wdata_i,
  output logic [port_io_pkg::PORT_W-1:0] p1_latch_o,
  output logic [port_io_pkg::PORT_W-1:0] p3_latch_o,
  output logic [port_io_pkg::PORT_W-1:0] p1_read_o,
  output logic [port_io_pkg::PORT_W-1:0] p3_read_o,
  // Secondary output sources
  input wire logic serial_sync_i,
  input wire logic rxd_out_i,
  input wire logic txd_i,
  input wire logic shift_clk_i,
  input wire logic wr_strobe_n_i,
  input wire logic rd_strobe_n_i,
  input wire logic [port_io_pkg::CC_N-1:0] cmp_en_i,
  input wire logic [port_io_pkg::CC_N-1:0] cmp_out_i,
  input wire logic system_clock_pin_en_i,
  input wire logic system_clock_pin_tick_i,
  input wire logic verify_mode_i,
  input wire logic [port_io_pkg::PORT_W-1:0] verify_addr_lo_i,
  // Secondary inputs towards peripherals
  output logic rxd_in_o,
  output logic ext_irq0_in_o,
  output logic timer0_gate_o,
  output logic count1_in_o,
  output logic count1_fall_o,
  output logic ext_irq2_in_o,
  output logic ext_irq3_in_o,
  output logic ext_irq4_in_o,
  output logic ext_irq5_in_o,
  output logic ext_irq6_in_o,
  output logic [port_io_pkg::CC_N-1:0] match_capture_pin_o,
  output logic reload_trigger_in_o,
  // Pins
  input wire logic [port_io_pkg::PORT_W-1:0] p1_pin_i,
  output logic [port_io_pkg::PORT_W-1:0] p1_pin_o,
  output logic [port_io_pkg::PORT_W-1:0] p1_pin_oe_o,
  input wire logic [port_io_pkg::PORT_W-1:0] p3_pin_i,
  output logic [port_io_pkg::PORT_W-1:0] p3_pin_o,
  output logic [port_io_pkg::PORT_W-1:0] p3_pin_oe_o
);
  import port_io_pkg::*;

  typedef struct packed {
    logic [PORT_W-1:0] p1_latch;
    logic [PORT_W-1:0] p3_latch;
    logic [PORT_W-1:0] p1_in;
    logic [PORT_W-1:0] p3_in;
    logic [PORT_W-1:0] p1_alt;
    logic [PORT_W-1:0] p3_alt;
    logic [PORT_W-1:0] p1_out;
    logic [PORT_W-1:0] p1_oe;
    logic [PORT_W-1:0] p3_out;
    logic [PORT_W-1:0] p3_oe;
    logic clk_tgl;
    logic cnt1_fall;
  } port_state_t;

  port_state_t q;
  port_state_t d;
  logic [PORT_W-1:0] p3_func;
  logic [PORT_W-1:0] p1_func;
  logic [PORT_W-1:0] p1_val;
  logic [PORT_W-1:0] p3_val;

  // Next state: latches, input sampling, pin drive
  always_comb
  begin
    d = q;
    p3_func = ALL_ONE;
    p1_func = ALL_ONE;
    if (p1_wr_i)
    begin
      d.p1_latch = p1_wdata_i; // see RULE2
    end
    if (p3_wr_i)
    begin
      d.p3_latch = p3_wdata_i; // see RULE1
    end
    // Raw pin level for port reads
    d.p1_in = p1_pin_i;
    d.p3_in = p3_pin_i;
    // A zero latch pulls the pin low, except first-port pins driven by compare or verify, so gating inputs also hides stale levels
    d.p3_alt = p3_pin_i & q.p3_latch; // see RULE3
    d.p1_alt = p1_pin_i & q.p1_latch; // see RULE4
    d.cnt1_fall = q.p3_alt[P3_CNT1] & ~d.p3_alt[P3_CNT1]; // see RULE8
    if (system_clock_pin_tick_i)
    begin
      d.clk_tgl = ~q.clk_tgl; // see RULE14
    end
    // Third-port secondary outputs; idle functions present a one
    p3_func[P3_RXD] = serial_sync_i ? rxd_out_i : 1'b1; // see RULE6
    p3_func[P3_TXD] = serial_sync_i ? shift_clk_i : txd_i; // see RULE6
    p3_func[P3_WR] = wr_strobe_n_i; // see RULE9
    p3_func[P3_RD] = rd_strobe_n_i; // see RULE10
    p3_val = q.p3_latch & p3_func; // see RULE15
    // Quasi-bidirectional: drive low only, the pullup gives the high level
    d.p3_out = p3_val; // see RULE1
    d.p3_oe = ~p3_val; // see RULE3
    // First-port outputs
    p1_func[P1_SYSTEM_CLOCK_PIN] = system_clock_pin_en_i ? q.clk_tgl : 1'b1; // see RULE14
    p1_val = q.p1_latch & p1_func; // see RULE15
    d.p1_out = p1_val; // see RULE2
    d.p1_oe = ~p1_val; // see RULE2
    for (int k = 0; k < CC_N; k++)
    begin
      if (cmp_en_i[k])
      begin
        // Compare output drives strongly and ignores the latch
        d.p1_out[k] = cmp_out_i[k]; // see RULE4
        d.p1_oe[k] = 1'b1; // see RULE11
      end
    end
    // Verification overrides every other drive of the first port pins
    if (verify_mode_i)
    begin
      d.p1_out = verify_addr_lo_i; // see RULE5
      d.p1_oe = ALL_ONE; // see RULE5
    end
  end

  // State register
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q.p1_latch <= LATCH_RST;
      q.p3_latch <= LATCH_RST;
      q.p1_in <= LATCH_RST;
      q.p3_in <= LATCH_RST;
      q.p1_alt <= LATCH_RST;
      q.p3_alt <= LATCH_RST;
      q.p1_out <= LATCH_RST;
      q.p1_oe <= OE_RST;
      q.p3_out <= LATCH_RST;
      q.p3_oe <= OE_RST;
      q.clk_tgl <= 1'b0;
      q.cnt1_fall <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state
  assign p1_latch_o = q.p1_latch;
  assign p3_latch_o = q.p3_latch;
  assign p1_read_o = q.p1_in;
  assign p3_read_o = q.p3_in;
  assign p1_pin_o = q.p1_out;
  assign p1_pin_oe_o = q.p1_oe;
  assign p3_pin_o = q.p3_out;
  assign p3_pin_oe_o = q.p3_oe;

  // Secondary inputs, one register behind the pins
  assign rxd_in_o = q.p3_alt[P3_RXD]; // see RULE6
  assign ext_irq0_in_o = q.p3_alt[P3_IRQ0]; // see RULE7
  assign timer0_gate_o = q.p3_alt[P3_IRQ0]; // see RULE7
  assign count1_in_o = q.p3_alt[P3_CNT1]; // see RULE8
  assign count1_fall_o = q.cnt1_fall;
  assign ext_irq3_in_o = q.p1_alt[P1_IRQ3]; // see RULE11
  assign ext_irq4_in_o = q.p1_alt[P1_IRQ4]; // see RULE11
  assign ext_irq5_in_o = q.p1_alt[P1_IRQ5]; // see RULE11
  assign ext_irq6_in_o = q.p1_alt[P1_IRQ6]; // see RULE11
  assign match_capture_pin_o = q.p1_alt[CC_N-1:0]; // see RULE11
  assign ext_irq2_in_o = q.p1_alt[P1_IRQ2]; // see RULE12
  assign reload_trigger_in_o = q.p1_alt[P1_RELOAD]; // see RULE13

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Latch writes land one cycle later
  property p_p3_write;
    p3_wr_i |=> (p3_latch_o == $past(p3_wdata_i));
  endproperty
  a_p3_write: assert property (p_p3_write) else $error("third port latch write lost"); // see RULE1

  // A zero latch never lets the pin go high
  property p_p3_latch_zero;
    1'b1 |=> ((p3_pin_o & ~$past(q.p3_latch)) == ALL_ZERO);
  endproperty
  a_p3_latch_zero: assert property (p_p3_latch_zero) else $error("third port pin high over zero latch"); // see RULE3

  // Plain first-port bit with latch one is released to the pullup
  property p_p1_release;
    (q.p1_latch[PORT_W-1] && !verify_mode_i) |=> !p1_pin_oe_o[PORT_W-1];
  endproperty
  a_p1_release: assert property (p_p1_release) else $error("first port bit 7 not released"); // see RULE2

  // Compare output follows its source whatever the latch holds
  property p_cmp_drive;
    (cmp_en_i[P1_IRQ3] && !verify_mode_i) |=> (p1_pin_oe_o[P1_IRQ3] && p1_pin_o[P1_IRQ3] == $past(cmp_out_i[P1_IRQ3]));
  endproperty
  a_cmp_drive: assert property (p_cmp_drive) else $error("compare output not driven"); // see RULE4

  // Verification puts the low address byte on the first port
  property p_verify;
    verify_mode_i |=> (p1_pin_o == $past(verify_addr_lo_i) && p1_pin_oe_o == ALL_ONE);
  endproperty
  a_verify: assert property (p_verify) else $error("verify address not on first port"); // see RULE5

  // Asynchronous transmit data reaches its pin
  property p_txd;
    (!serial_sync_i && q.p3_latch[P3_TXD]) |=> (p3_pin_o[P3_TXD] == $past(txd_i));
  endproperty
  a_txd: assert property (p_txd) else $error("transmit data not on pin"); // see RULE6

  // Low interrupt 0 pin reaches interrupt and gate together
  sequence s_irq0_low;
    !p3_pin_i[P3_IRQ0] && q.p3_latch[P3_IRQ0];
  endsequence
  property p_irq0;
    s_irq0_low |=> (!ext_irq0_in_o && !timer0_gate_o);
  endproperty
  a_irq0: assert property (p_irq0) else $error("interrupt 0 level not passed"); // see RULE7

  // High then low on the count pin gives one falling-edge pulse
  sequence s_cnt_high;
    p3_pin_i[P3_CNT1] && q.p3_latch[P3_CNT1];
  endsequence
  sequence s_cnt_low;
    !p3_pin_i[P3_CNT1] && q.p3_latch[P3_CNT1];
  endsequence
  property p_cnt_fall;
    s_cnt_high ##1 s_cnt_low |=> count1_fall_o ##1 !count1_fall_o;
  endproperty
  a_cnt_fall: assert property (p_cnt_fall) else $error("counter 1 edge missed"); // see RULE8

  // Active write strobe pulls its pin low
  property p_wr_strobe;
    (!wr_strobe_n_i && q.p3_latch[P3_WR]) |=> (!p3_pin_o[P3_WR] && p3_pin_oe_o[P3_WR]);
  endproperty
  a_wr_strobe: assert property (p_wr_strobe) else $error("write strobe not on pin"); // see RULE9

  // Active read strobe pulls its pin low
  property p_rd_strobe;
    (!rd_strobe_n_i && q.p3_latch[P3_RD]) |=> (!p3_pin_o[P3_RD] && p3_pin_oe_o[P3_RD]);
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("read strobe not on pin"); // see RULE10

  // Clock output shows the divided toggle
  property p_system_clock_pin;
    (system_clock_pin_en_i && !verify_mode_i && q.p1_latch[P1_SYSTEM_CLOCK_PIN]) |=> (p1_pin_o[P1_SYSTEM_CLOCK_PIN] == $past(q.clk_tgl));
  endproperty
  a_system_clock_pin: assert property (p_system_clock_pin) else $error("clock output wrong"); // see RULE14

  // Capture input 0 follows its pin one cycle later under a one latch
  property p_capture;
    q.p1_latch[P1_IRQ3] |=> (match_capture_pin_o[P1_IRQ3] == $past(p1_pin_i[P1_IRQ3]));
  endproperty
  a_capture: assert property (p_capture) else $error("capture input not passed"); // see RULE11

  // Synchronous serial data reaches bit 0 under a one latch
  property p_sync_data;
    (serial_sync_i && q.p3_latch[P3_RXD]) |=> (p3_pin_o[P3_RXD] == $past(rxd_out_i));
  endproperty
  a_sync_data: assert property (p_sync_data) else $error("sync serial data not on pin"); // see RULE6

  // Shift clock takes the place of transmit data in synchronous mode
  property p_shift_clk;
    (serial_sync_i && q.p3_latch[P3_TXD]) |=> (p3_pin_o[P3_TXD] == $past(shift_clk_i));
  endproperty
  a_shift_clk: assert property (p_shift_clk) else $error("shift clock not on pin"); // see RULE6

  // Count input follows its pin one cycle later under a one latch
  property p_count1;
    q.p3_latch[P3_CNT1] |=> (count1_in_o == $past(p3_pin_i[P3_CNT1]));
  endproperty
  a_count1: assert property (p_count1) else $error("counter 1 input not passed"); // see RULE8

  // Interrupt 2 follows its pin one cycle later under a one latch
  property p_irq2;
    q.p1_latch[P1_IRQ2] |=> (ext_irq2_in_o == $past(p1_pin_i[P1_IRQ2]));
  endproperty
  a_irq2: assert property (p_irq2) else $error("interrupt 2 level not passed"); // see RULE12

  // Reload trigger follows its pin one cycle later under a one latch
  property p_reload;
    q.p1_latch[P1_RELOAD] |=> (reload_trigger_in_o == $past(p1_pin_i[P1_RELOAD]));
  endproperty
  a_reload: assert property (p_reload) else $error("reload trigger not passed"); // see RULE13

  // Read strobe pin is latch AND strobe, so a zero latch holds it low
  property p_rd_and;
    1'b1 |=> (p3_pin_o[P3_RD] == ($past(q.p3_latch[P3_RD]) && $past(rd_strobe_n_i)));
  endproperty
  a_rd_and: assert property (p_rd_and) else $error("read strobe pin not latch and strobe"); // see RULE15

  // Outside verification, plain first-port bits never go high over a zero latch; compare bits are exempt
  property p_p1_latch_zero;
    !verify_mode_i |=> ((p1_pin_o & ~$past(q.p1_latch) & ~{{(PORT_W-CC_N){1'b0}}, $past(cmp_en_i)}) == ALL_ZERO);
  endproperty
  a_p1_latch_zero: assert property (p_p1_latch_zero) else $error("first port pin high over zero latch"); // see RULE4

  // Port read shows the raw pin level one cycle later, whatever the latch holds
  property p_p3_read;
    1'b1 |=> (p3_read_o == $past(p3_pin_i));
  endproperty
  a_p3_read: assert property (p_p3_read) else $error("third port read not the pin level"); // see RULE1

endmodule
`default_nettype wire

// File: src/port_io_pkg.sv
// Notes on behaviour
// RULE1: Eight third-port pins each have a latch and pullup; latch one lets pin be input.
// RULE2: Eight first-port pins each have a latch and pullup; latch one leaves pin weakly high.
// RULE3: Third-port secondary functions work only while the pin latch holds one.
// RULE4: First-port functions need latch one, except compare outputs which drive regardless.
// RULE5: First port carries the low address byte during program verification.
// RULE6: Third bit 0 is serial receive or sync data; bit 1 transmit or shift clock.
// RULE7: Third bit 2 is external interrupt 0 input and timer 0 gate input.
// RULE8: Third bit 5 is the external count input of counter 1.
// RULE9: Third bit 6 outputs the external data memory write strobe.
// RULE10: Third bit 7 outputs the external data memory read strobe.
// RULE11: First bits 0 to 3 are interrupts 3 to 6, compare outputs and capture inputs.
// RULE12: First bit 4 is the external interrupt 2 input.
// RULE13: First bit 5 is the timer 2 external reload trigger input.
// RULE14: First bit 6 outputs the system clock in its secondary role.
// RULE15: Latch-gated secondary output value is latch bit AND function output.
package port_io_pkg;
  localparam int PORT_W = 8;
  localparam int CC_N = 4;
  // Reset values, plus all-ones and all-zeros constants
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] OE_RST = 8'h00;
  localparam logic [7:0] ALL_ONE = 8'hFF;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  // Third-port bit positions
  localparam int P3_RXD = 0;
  localparam int P3_TXD = 1;
  localparam int P3_IRQ0 = 2;
  localparam int P3_CNT1 = 5;
  localparam int P3_WR = 6;
  localparam int P3_RD = 7;
  // First-port bit positions
  localparam int P1_IRQ3 = 0;
  localparam int P1_IRQ4 = 1;
  localparam int P1_IRQ5 = 2;
  localparam int P1_IRQ6 = 3;
  localparam int P1_IRQ2 = 4;
  localparam int P1_RELOAD = 5;
  localparam int P1_SYSTEM_CLOCK_PIN = 6;
endpackage

// File: bench/pin_board.sv
`timescale 1ns/100ps
`default_nettype none
// Board side of one port: weak pullups plus optional external drivers
module pin_board
(
  input wire logic [7:0] pin_o_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_v_i,
  output logic [7:0] pad_o
);
  // Chip drive wins, a board driver next; a released line floats up to one
  always_comb pad_o = (oe_i & pin_o_i) | (~oe_i & ext_en_i & ext_v_i) | (~oe_i & ~ext_en_i);
endmodule
`default_nettype wire

// File: bench/tb_port1_port3_alt_function_io.sv
`timescale 1ns/100ps
`default_nettype none
module tb_port1_port3_alt_function_io;
  import port_io_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic p1w = 1'b0, p3w = 1'b0, ss = 1'b0, rxo = 1'b1, txd = 1'b1, shc = 1'b1, wrn = 1'b1, rdn = 1'b1;
  logic cke = 1'b0, tk = 1'b0, vm = 1'b0;
  logic [3:0] cen = 4'h0, cout = 4'h0;
  logic [7:0] wd = 8'h00, va = 8'h00, e1en = 8'h00, e1v = 8'h00, e3en = 8'h00, e3v = 8'h00;
  logic [7:0] p1l, p3l, p1o, p1oe, p3o, p3oe, p1pad, p3pad, p1r, p3r;
  logic rxi, irq0, gate0, cnt1, fall1, irq2, irq3, irq4, irq5, irq6, rld;
  logic [3:0] mc;
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;

  port_alt_io uut (.clk_i(clk_i), .rstn_i(rstn_i), .p1_wr_i(p1w), .p1_wdata_i(wd), .p3_wr_i(p3w), .p3_wdata_i(wd),
    .p1_latch_o(p1l), .p3_latch_o(p3l), .p1_read_o(p1r), .p3_read_o(p3r), .serial_sync_i(ss), .rxd_out_i(rxo),
    .txd_i(txd), .shift_clk_i(shc), .wr_strobe_n_i(wrn), .rd_strobe_n_i(rdn), .cmp_en_i(cen), .cmp_out_i(cout),
    .system_clock_pin_en_i(cke), .system_clock_pin_tick_i(tk), .verify_mode_i(vm), .verify_addr_lo_i(va), .rxd_in_o(rxi),
    .ext_irq0_in_o(irq0), .timer0_gate_o(gate0), .count1_in_o(cnt1), .count1_fall_o(fall1), .ext_irq2_in_o(irq2),
    .ext_irq3_in_o(irq3), .ext_irq4_in_o(irq4), .ext_irq5_in_o(irq5), .ext_irq6_in_o(irq6),
    .match_capture_pin_o(mc), .reload_trigger_in_o(rld), .p1_pin_i(p1pad), .p1_pin_o(p1o), .p1_pin_oe_o(p1oe),
    .p3_pin_i(p3pad), .p3_pin_o(p3o), .p3_pin_oe_o(p3oe));
  pin_board b1 (.pin_o_i(p1o), .oe_i(p1oe), .ext_en_i(e1en), .ext_v_i(e1v), .pad_o(p1pad));
  pin_board b3 (.pin_o_i(p3o), .oe_i(p3oe), .ext_en_i(e3en), .ext_v_i(e3v), .pad_o(p3pad));

  // Free-running core clock
  always #10 clk_i = ~clk_i;

  // Hang guard, well beyond the 59 or so cycles the run needs
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Lands one ns after the edge so registered outputs have settled
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic sel, input logic [7:0] v);
    @(posedge clk_i);
    p1w <= !sel;
    p3w <= sel;
    wd <= v;
    @(posedge clk_i);
    p1w <= 1'b0;
    p3w <= 1'b0;
    tick(1);
  endtask

  task automatic t_gate();
    wr(1'b1, ALL_ZERO);
    chk("p3 drive", 16'h00FF, {p3o, p3oe});
    tick(1);
    chk("p3 alt in", 16'h0000, {rxi, irq0, gate0, cnt1});
    wr(1'b1, ALL_ONE);
    tick(1);
    chk("p3 release", 16'hFF00, {p3pad, p3oe});
  endtask

  task automatic t_strobe();
    @(posedge clk_i);
    wrn <= 1'b0;
    tick(1);
    chk("wr strobe", 16'h0006, {p3oe[7:6], p3pad[7:6]});
    @(posedge clk_i);
    wrn <= 1'b1;
    rdn <= 1'b0;
    tick(1);
    chk("rd strobe", 16'h0009, {p3oe[7:6], p3pad[7:6]});
    @(posedge clk_i);
    rdn <= 1'b1;
  endtask

  task automatic t_serial();
    @(posedge clk_i);
    txd <= 1'b0;
    tick(1);
    chk("async txd", 16'h0001, p3pad[1:0]);
    @(posedge clk_i);
    txd <= 1'b1;
    ss <= 1'b1;
    rxo <= 1'b0;
    shc <= 1'b0;
    tick(1);
    chk("sync data clk", 16'h0000, p3pad[1:0]);
    @(posedge clk_i);
    ss <= 1'b0;
    rxo <= 1'b1;
    shc <= 1'b1;
    e3en <= 8'h25;
    tick(1);
    chk("p3 inputs", 16'h0001, {rxi, irq0, gate0, cnt1, fall1});
    chk("p3 read", 16'h00D8, p3r);
    tick(1);
    chk("count fall", 16'h0000, fall1);
    @(posedge clk_i);
    e3en <= 8'h00;
  endtask

  task automatic t_p1();
    @(posedge clk_i);
    e1en <= 8'h3F;
    e1v <= 8'h2A;
    tick(1);
    chk("p1 alt in", 16'h02AA, {6'h00, rld, irq2, irq6, irq5, irq4, irq3, mc});
    chk("p1 read", 16'h00EA, p1r);
    @(posedge clk_i);
    e1en <= 8'h00;
    wr(1'b0, ALL_ZERO);
    @(posedge clk_i);
    cen <= 4'hF;
    cout <= 4'hA;
    tick(1);
    chk("compare", 16'h0AFF, {p1o, p1oe});
    @(posedge clk_i);
    cen <= 4'h0;
    vm <= 1'b1;
    va <= 8'hA5;
    tick(1);
    chk("verify addr", 16'hA5FF, {p1o, p1oe});
    chk("capture gated", 16'h0000, mc);
    @(posedge clk_i);
    vm <= 1'b0;
    wr(1'b0, ALL_ONE);
  endtask

  task automatic t_system_clock_pin();
    logic a;
    @(posedge clk_i);
    cke <= 1'b1;
    repeat (2)
    begin
      @(posedge clk_i);
      tk <= 1'b1;
      @(posedge clk_i);
      tk <= 1'b0;
      tick(2);
      a = p1pad[6];
    end
    @(posedge clk_i);
    tk <= 1'b1;
    @(posedge clk_i);
    tk <= 1'b0;
    tick(2);
    chk("clock out", {15'h0, ~a}, {15'h0, p1pad[6]});
  endtask

  // Mid-run reset: latches return to one and every pin is released
  task automatic t_reset();
    wr(1'b1, ALL_ZERO);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    cke <= 1'b0;
    tick(1);
    chk("mid reset latch", 16'hFFFF, {p3l, p1l});
    @(posedge clk_i);
    rstn_i <= 1'b1;
    tick(1);
    chk("mid reset oe", 16'h0000, {p3oe, p1oe});
  endtask

  task automatic summarize();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    tick(1);
    chk("reset latch", 16'hFFFF, {p3l, p1l});
    chk("reset oe", 16'h0000, {p3oe, p1oe});
    t_gate();
    t_strobe();
    t_serial();
    t_p1();
    t_system_clock_pin();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
